/* rtl/sfdtp_top.sv */
// Frame-start pulse logic: delay, skew tracking, pin routing, registers.
// Assumes line events and link status come from logic on i_mclk.
`timescale 1ns/1ps
`default_nettype none

module sfdtp_top (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_sys_rst,
  // Register port
  input  wire logic [9:0]  i_reg_addr,
  input  wire logic [15:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [15:0] o_reg_rdata,
  // Line path status
  input  wire logic        i_tx_delim_on_line,
  input  wire logic        i_rx_first_symbol,
  input  wire logic        i_link_up,
  input  wire logic        i_speed_1000,
  input  wire logic        i_master_role,
  input  wire logic [4:0]  i_align_skew,
  // Pins and restart
  output logic      [3:0]  o_sfd_pins,
  output logic             o_soft_restart
);

  // Software registers
  logic [15:0] ctrl_q;       // Control, restart bit reads zero
  logic [15:0] sync_q;       // Sync FIFO control
  logic [15:0] rcfg_q;       // Receive configuration
  logic [15:0] mux1_q;       // Pins 0 and 1 select
  logic [15:0] mux2_q;       // Pins 2 and 3 select
  logic [15:0] phase_q;      // Baseline phase nibbles

  // Link and skew state
  logic        link_q;       // Link one cycle ago
  logic        skew_valid_q; // Readout trustworthy
  logic [3:0]  skew_lock_q;  // Skew of current link
  logic [15:0] skew_stat_q;  // Skew status as read

  // Derived
  logic        link_rise;    // New link this cycle
  logic        sync_ok;      // Init value loaded
  logic        ext_en;       // Pulses allowed
  logic [3:0]  skew_clamp;   // Bounded alignment skew
  logic [7:0]  tx_delay_ns;  // Transmit delay
  logic [7:0]  rx_delay_ns;  // Receive delay
  logic        tx_dly;       // Delayed transmit pulse
  logic        rx_dly;       // Delayed receive pulse
  logic [15:0] sel_all;      // All pin selects

  // Write decodes
  logic wr_ctrl;
  logic wr_sync;
  logic wr_rcfg;
  logic wr_mux1;
  logic wr_mux2;
  logic wr_phase;

  assign wr_ctrl  = i_reg_wr && (i_reg_addr == sfdtp_pkg::ADDR_CTRL);
  assign wr_sync  = i_reg_wr && (i_reg_addr == sfdtp_pkg::ADDR_SYNC);
  assign wr_rcfg  = i_reg_wr && (i_reg_addr == sfdtp_pkg::ADDR_RCFG);
  assign wr_mux1  = i_reg_wr && (i_reg_addr == sfdtp_pkg::ADDR_MUX1);
  assign wr_mux2  = i_reg_wr && (i_reg_addr == sfdtp_pkg::ADDR_MUX2);
  assign wr_phase = i_reg_wr && (i_reg_addr == sfdtp_pkg::ADDR_PHASE);

  // Control; restart bit never stored
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      ctrl_q <= sfdtp_pkg::RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl_q <= i_reg_wdata & ~(16'h0001 << sfdtp_pkg::CTRL_RESTART_BIT);
    end
  end

  // Restart pulse to the link engine
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_soft_restart <= 1'b0;
    end else begin
      o_soft_restart <= wr_ctrl && i_reg_wdata[sfdtp_pkg::CTRL_RESTART_BIT];
    end
  end

  // Sync FIFO control
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      sync_q <= sfdtp_pkg::RST_SYNC;
    end else if (wr_sync) begin
      sync_q <= i_reg_wdata;
    end
  end

  // Receive configuration
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      rcfg_q <= sfdtp_pkg::RST_RCFG;
    end else if (wr_rcfg) begin
      rcfg_q <= i_reg_wdata;
    end
  end

  // Pin mux selects
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      mux1_q <= sfdtp_pkg::RST_MUX;
      mux2_q <= sfdtp_pkg::RST_MUX;
    end else begin
      if (wr_mux1) begin
        mux1_q <= i_reg_wdata;
      end
      if (wr_mux2) begin
        mux2_q <= i_reg_wdata;
      end
    end
  end

  // Baseline phase
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      phase_q <= sfdtp_pkg::RST_PHASE;
    end else if (wr_phase) begin
      phase_q <= i_reg_wdata;
    end
  end

  // Status decodes
  assign link_rise = i_link_up && !link_q;
  assign sync_ok   = (sync_q == sfdtp_pkg::SYNC_INIT_VAL);
  assign ext_en    = rcfg_q[sfdtp_pkg::RCFG_EXT_EN_BIT];

  // Wider skews are clipped; the readout cannot overflow its nibble
  assign skew_clamp = (i_align_skew > {1'b0, sfdtp_pkg::SKEW_LIMIT}) ?
                      sfdtp_pkg::SKEW_LIMIT : i_align_skew[3:0];

  // Link history for edge detection
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      link_q <= 1'b0;
    end else begin
      link_q <= i_link_up;
    end
  end

  // Skew caught once per link, held until the link drops
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      skew_lock_q <= 4'h0;
    end else if (!i_link_up) begin
      skew_lock_q <= 4'h0;
    end else if (link_rise) begin
      // Zero unless the link runs at gigabit
      skew_lock_q <= i_speed_1000 ? skew_clamp : 4'h0;
    end
  end

  // Valid only for a link formed after the init value was loaded
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      skew_valid_q <= 1'b0;
    end else if (!i_link_up || o_soft_restart || !sync_ok || !i_speed_1000) begin
      skew_valid_q <= 1'b0;
    end else if (link_rise) begin
      skew_valid_q <= 1'b1;
    end
  end

  // Status word; only the active role's nibble is filled
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      skew_stat_q <= 16'h0000;
    end else if (skew_valid_q && i_speed_1000) begin
      skew_stat_q <= 16'h0000;
      skew_stat_q[sfdtp_pkg::SKEW_VALID_BIT] <= 1'b1;
      if (i_master_role) begin
        skew_stat_q[sfdtp_pkg::SKEW_MST_LSB +: 4] <= skew_lock_q;
      end else begin
        skew_stat_q[sfdtp_pkg::SKEW_SLV_LSB +: 4] <= skew_lock_q;
      end
    end else begin
      // Nothing to report at 100Mb or while the readout is not valid
      skew_stat_q <= 16'h0000;
    end
  end

  // Delays in nanoseconds: phase steps, plus alignment skew on receive
  assign tx_delay_ns = 8'({4'h0, phase_q[sfdtp_pkg::PHASE_TX_LSB +: 4]}
                          * sfdtp_pkg::STEP_NS);
  assign rx_delay_ns = 8'(({4'h0, phase_q[sfdtp_pkg::PHASE_RX_LSB +: 4]}
                          + (i_speed_1000 ? {4'h0, skew_lock_q} : 8'h00))
                          * sfdtp_pkg::STEP_NS);

  // Transmit path: event marks the delimiter placed on the line
  sfdtp_delay u_tx_delay (
    .i_mclk     (i_mclk),
    .i_sys_rst  (i_sys_rst),
    .i_pulse    (i_tx_delim_on_line && ext_en),
    .i_delay_ns (tx_delay_ns),
    .o_pulse    (tx_dly)
  );

  // Receive path: event marks the first received symbol
  sfdtp_delay u_rx_delay (
    .i_mclk     (i_mclk),
    .i_sys_rst  (i_sys_rst),
    .i_pulse    (i_rx_first_symbol && ext_en),
    .i_delay_ns (rx_delay_ns),
    .o_pulse    (rx_dly)
  );

  // Shared pulse bundle for the pin muxes
  sfdtp_pulse_if pulse_bus ();

  assign pulse_bus.tx_pulse = tx_dly;
  assign pulse_bus.rx_pulse = rx_dly;
  assign pulse_bus.enable   = ext_en;

  // Pins 0 and 1 from the first mux register, 2 and 3 from the second
  assign sel_all = {mux2_q[7:0], mux1_q[7:0]};

  // One registered mux per pin
  for (genvar k = 0; k < sfdtp_pkg::NUM_PINS; k++) begin : g_pin
    sfdtp_pin_mux u_mux (
      .i_mclk    (i_mclk),
      .i_sys_rst (i_sys_rst),
      .bus       (pulse_bus),
      .i_sel     (sel_all[k*sfdtp_pkg::SEL_W +: sfdtp_pkg::SEL_W]),
      .o_pin     (o_sfd_pins[k])
    );
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 16'h0000;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        sfdtp_pkg::ADDR_CTRL:  o_reg_rdata <= ctrl_q;
        sfdtp_pkg::ADDR_SKEW:  o_reg_rdata <= skew_stat_q;
        sfdtp_pkg::ADDR_SYNC:  o_reg_rdata <= sync_q;
        sfdtp_pkg::ADDR_RCFG:  o_reg_rdata <= rcfg_q;
        sfdtp_pkg::ADDR_MUX1:  o_reg_rdata <= mux1_q;
        sfdtp_pkg::ADDR_MUX2:  o_reg_rdata <= mux2_q;
        sfdtp_pkg::ADDR_PHASE: o_reg_rdata <= phase_q;
        // Unmapped reads as zero
        default:               o_reg_rdata <= 16'h0000;
      endcase
    end else begin
      o_reg_rdata <= 16'h0000;
    end
  end

  // Checks

  // Transmit event at phase 1 leaves the delay two cycles later
  sequence s_tx_phase1;
    i_tx_delim_on_line && ext_en && (tx_delay_ns == 8'h08);
  endsequence

  property p_tx_phase;
    @(posedge i_mclk) disable iff (i_sys_rst)
      s_tx_phase1 ##1 !i_tx_delim_on_line |=> tx_dly;
  endproperty
  a_tx_phase: assert property (p_tx_phase)
    else $error("transmit pulse not shifted by one step");

  // Receive event at zero delay leaves next cycle, then drops
  property p_rx_single;
    @(posedge i_mclk) disable iff (i_sys_rst)
      (i_rx_first_symbol && ext_en && rx_delay_ns == 8'h00
       ##1 !i_rx_first_symbol) |-> rx_dly ##1 !rx_dly;
  endproperty
  a_rx_single: assert property (p_rx_single)
    else $error("receive pulse not one cycle wide");

  // No pin moves while disabled
  property p_gate;
    @(posedge i_mclk) disable iff (i_sys_rst)
      !ext_en ##1 !ext_en |=> (o_sfd_pins == 4'h0);
  endproperty
  a_gate: assert property (p_gate)
    else $error("pin pulsed while feature disabled");

  // Pin 0 follows its select
  property p_route;
    @(posedge i_mclk) disable iff (i_sys_rst)
      (mux1_q[3:0] == sfdtp_pkg::SEL_TX) && tx_dly && ext_en |=> o_sfd_pins[0];
  endproperty
  a_route: assert property (p_route)
    else $error("pin 0 missed selected transmit pulse");

  // Restart bit yields one pulse
  sequence s_restart_wr;
    wr_ctrl && i_reg_wdata[sfdtp_pkg::CTRL_RESTART_BIT];
  endsequence

  property p_restart;
    @(posedge i_mclk) disable iff (i_sys_rst)
      s_restart_wr ##1 !wr_ctrl |-> o_soft_restart ##1 !o_soft_restart;
  endproperty
  a_restart: assert property (p_restart)
    else $error("soft restart pulse wrong");

  // Without init the readout is never valid
  property p_need_init;
    @(posedge i_mclk) disable iff (i_sys_rst)
      !sync_ok |=> !skew_valid_q;
  endproperty
  a_need_init: assert property (p_need_init)
    else $error("skew valid without init value");

  // Skew frozen while the link stays up
  property p_hold;
    @(posedge i_mclk) disable iff (i_sys_rst)
      i_link_up && link_q |=> $stable(skew_lock_q) || !i_link_up;
  endproperty
  a_hold: assert property (p_hold)
    else $error("skew changed during link");

  // Master report two cycles after a valid gigabit link forms
  property p_master;
    @(posedge i_mclk) disable iff (i_sys_rst)
      link_rise && sync_ok && i_speed_1000 && !o_soft_restart
      ##1 (i_link_up && i_speed_1000 && i_master_role && sync_ok
           && !o_soft_restart)
      |=> skew_stat_q[sfdtp_pkg::SKEW_MST_LSB +: 4] == $past(skew_lock_q)
          && skew_stat_q[sfdtp_pkg::SKEW_SLV_LSB +: 4] == 4'h0;
  endproperty
  a_master: assert property (p_master)
    else $error("master skew nibble wrong");

  // Slow mode reports nothing
  property p_slow;
    @(posedge i_mclk) disable iff (i_sys_rst)
      !i_speed_1000 |=> skew_stat_q == 16'h0000;
  endproperty
  a_slow: assert property (p_slow)
    else $error("skew reported outside gigabit");

  // Captured skew respects the limit
  property p_limit;
    @(posedge i_mclk) disable iff (i_sys_rst)
      link_rise && i_speed_1000 && i_align_skew > 5'h0f |=> skew_lock_q == 4'hf;
  endproperty
  a_limit: assert property (p_limit)
    else $error("skew not clamped");

endmodule : sfdtp_top

`default_nettype wire

/* common/sfdtp_pkg.sv */
// Constants, register map and select codes for the frame-start pulse block.
// Assumes a 100 MHz core clock and a 16-bit management register port.
`default_nettype none

package sfdtp_pkg;

  // Register offsets
  localparam logic [9:0] ADDR_CTRL  = 10'h01f;  // Control, soft restart
  localparam logic [9:0] ADDR_SKEW  = 10'h055;  // Skew status, read only
  localparam logic [9:0] ADDR_SYNC  = 10'h0e9;  // Sync FIFO control
  localparam logic [9:0] ADDR_RCFG  = 10'h134;  // Receive configuration
  localparam logic [9:0] ADDR_MUX1  = 10'h171;  // Pin mux, pins 0 and 1
  localparam logic [9:0] ADDR_MUX2  = 10'h172;  // Pin mux, pins 2 and 3
  localparam logic [9:0] ADDR_PHASE = 10'h190;  // Baseline phase

  // Field positions
  localparam int CTRL_RESTART_BIT = 14;  // Self-clearing restart
  localparam int RCFG_EXT_EN_BIT  = 7;   // Extended MAC feature enable
  localparam int SKEW_MST_LSB     = 4;   // Master skew nibble
  localparam int SKEW_SLV_LSB     = 0;   // Slave skew nibble
  localparam int SKEW_VALID_BIT   = 15;  // Skew readout valid
  localparam int PHASE_TX_LSB     = 0;   // Transmit phase nibble
  localparam int PHASE_RX_LSB     = 4;   // Receive phase nibble
  localparam int SEL_W            = 4;   // Select field per pin
  localparam int NUM_PINS         = 4;   // Output pins

  // Reset values
  localparam logic [15:0] RST_CTRL  = 16'h0000;
  localparam logic [15:0] RST_SYNC  = 16'h0000;
  localparam logic [15:0] RST_RCFG  = 16'h0000;
  localparam logic [15:0] RST_MUX   = 16'h0000;
  localparam logic [15:0] RST_PHASE = 16'h0000;

  // Value software must load before a gigabit link
  localparam logic [15:0] SYNC_INIT_VAL = 16'hdf22;

  // Timing
  localparam int         CLK_FREQ_MHZ  = 100;
  localparam logic [7:0] CLK_PERIOD_NS = 8'(1000 / CLK_FREQ_MHZ);
  localparam logic [7:0] STEP_NS       = 8'h08;  // Phase and skew unit
  localparam logic [3:0] SKEW_LIMIT    = 4'hf;   // Largest skew reported

  // Pin select codes
  typedef enum logic [3:0] {
    SEL_OFF = 4'h0,
    SEL_TX  = 4'h1,
    SEL_RX  = 4'h2
  } sfdtp_sel_t;

endpackage : sfdtp_pkg

`default_nettype wire

/* common/sfdtp_pulse_if.sv */
// Delayed frame-start pulses and the output enable, fanned out to pin muxes.
// Assumes every user runs on the same core clock.
`timescale 1ns/1ps
`default_nettype none

interface sfdtp_pulse_if;
  logic tx_pulse;  // Delayed transmit pulse
  logic rx_pulse;  // Delayed receive pulse
  logic enable;    // Pulses allowed out

  modport src  (output tx_pulse, output rx_pulse, output enable);
  modport sink (input tx_pulse, input rx_pulse, input enable);
endinterface : sfdtp_pulse_if

`default_nettype wire

/* rtl/sfdtp_delay.sv */
// Delays a single-cycle pulse by a programmable time in nanoseconds.
// Assumes pulses are further apart than the longest delay.
`timescale 1ns/1ps
`default_nettype none

module sfdtp_delay (
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_sys_rst,
  // Pulse path
  input  wire logic       i_pulse,
  input  wire logic [7:0] i_delay_ns,
  output logic            o_pulse
);

  logic       busy_q;  // Waiting to fire
  logic [7:0] rem_q;   // Nanoseconds left

  // Countdown in core periods; a partial period rounds up
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      busy_q  <= 1'b0;
      rem_q   <= 8'h00;
      o_pulse <= 1'b0;
    end else if (i_pulse) begin
      // New pulse restarts the wait
      busy_q  <= (i_delay_ns != 8'h00);
      rem_q   <= i_delay_ns;
      o_pulse <= (i_delay_ns == 8'h00);
    end else if (busy_q && rem_q <= sfdtp_pkg::CLK_PERIOD_NS) begin
      busy_q  <= 1'b0;
      rem_q   <= 8'h00;
      o_pulse <= 1'b1;
    end else begin
      rem_q   <= busy_q ? rem_q - sfdtp_pkg::CLK_PERIOD_NS : 8'h00;
      o_pulse <= 1'b0;
    end
  end

endmodule : sfdtp_delay

`default_nettype wire

/* rtl/sfdtp_pin_mux.sv */
// One output pin: picks the transmit or receive pulse, or nothing.
// Assumes the pulse interface is driven on the same clock.
`timescale 1ns/1ps
`default_nettype none

module sfdtp_pin_mux (
  // Clock and reset
  input  wire logic                         i_mclk,
  input  wire logic                         i_sys_rst,
  // Pulse source
  sfdtp_pulse_if.sink                       bus,
  // Select and pin
  input  wire logic [sfdtp_pkg::SEL_W-1:0]  i_sel,
  output logic                              o_pin
);

  // Registered pin; unknown codes keep the pin low
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_pin <= 1'b0;
    end else begin
      o_pin <= bus.enable &&
               ((i_sel == sfdtp_pkg::SEL_TX && bus.tx_pulse) ||
                (i_sel == sfdtp_pkg::SEL_RX && bus.rx_pulse));
    end
  end

endmodule : sfdtp_pin_mux

`default_nettype wire

/* test/sfdtp_capture_model.sv */
// Capture-side model: samples the frame-start pins like timestamp logic.
// Assumes the pins are registered on i_mclk and reset with it.
`timescale 1ns/1ps
`default_nettype none

module sfdtp_capture_model (
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_sys_rst,
  // Pins under capture
  input  wire logic [3:0] i_pins,
  // Capture results
  output logic      [7:0] o_count,
  output logic            o_wide
);
  logic [3:0] prev_q;  // Pins one cycle ago

  // Count pulse starts; a pin high twice running is a wide pulse
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      prev_q  <= 4'h0;
      o_count <= 8'h00;
      o_wide  <= 1'b0;
    end else begin
      prev_q  <= i_pins;
      o_count <= o_count + 8'($countones(i_pins & ~prev_q));
      if ((i_pins & prev_q) != 4'h0) begin
        o_wide <= 1'b1;
      end
    end
  end
endmodule : sfdtp_capture_model

`default_nettype wire

/* test/sfdtp_top_tb.sv */
// Self-checking bench for the frame-start pulse block.
// Assumes the design sources and the capture model are compiled first.
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

module sfdtp_top_tb;
  // Clock, reset and register port
  logic        clk, rst, wr, rd;
  logic [9:0]  addr;
  logic [15:0] wdata, rdata, d;
  // Line path stimulus
  logic        tx_ev, rx_ev, tx_req, rx_req, link, gig, mst;
  logic [4:0]  skew, s;
  logic [3:0]  t, r;
  // Outputs and capture results
  logic [3:0]  pins;
  logic        restart, wide;
  logic [7:0]  cap_cnt;
  int          errors, tests_run, seed, n, exp_cnt;
  // Address lists for the reset and read-write passes
  logic [9:0]  dut_addrs [8] = '{sfdtp_pkg::ADDR_CTRL, sfdtp_pkg::ADDR_SKEW,
    sfdtp_pkg::ADDR_SYNC, sfdtp_pkg::ADDR_RCFG, sfdtp_pkg::ADDR_MUX1,
    sfdtp_pkg::ADDR_MUX2, sfdtp_pkg::ADDR_PHASE, 10'h3ff};
  logic [9:0]  rw_addrs [5] = '{sfdtp_pkg::ADDR_SYNC, sfdtp_pkg::ADDR_RCFG,
    sfdtp_pkg::ADDR_MUX1, sfdtp_pkg::ADDR_MUX2, sfdtp_pkg::ADDR_PHASE};
  logic [15:0] wdata_r;  // Random value under test

  sfdtp_top dut (.i_mclk(clk), .i_sys_rst(rst), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_tx_delim_on_line(tx_ev),
    .i_rx_first_symbol(rx_ev), .i_link_up(link), .i_speed_1000(gig),
    .i_master_role(mst), .i_align_skew(skew), .o_sfd_pins(pins),
    .o_soft_restart(restart));

  sfdtp_capture_model cap (.i_mclk(clk), .i_sys_rst(rst), .i_pins(pins),
    .o_count(cap_cnt), .o_wide(wide));

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Line events: one-cycle pulse launched on the rising edge
  always @(posedge clk) begin
    tx_ev  <= tx_req;
    rx_ev  <= rx_req;
    tx_req <= 1'b0;
    rx_req <= 1'b0;
  end

  // Pin delay in cycles for a delay in ns; a partial 10ns period rounds up
  function int lat(input int d_ns);
    return 2 + (d_ns + 9) / 10;
  endfunction : lat

  // Skew readout: valid flag and clamped nibble by role
  function logic [15:0] exp_stat(input logic [4:0] sk, input logic m);
    logic [15:0] v;
    v = 16'((sk > 5'd15) ? 5'd15 : sk);
    return 16'h8000 | (m ? (v << 4) : v);
  endfunction : exp_stat

  task wr_reg(input logic [9:0] a, input logic [15:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  // Data stand only in the cycle after the strobe
  task rd_reg(input logic [9:0] a, output logic [15:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg

  // One event, then cycles until the pin rises; 40 means none seen
  task fire(input logic is_rx, input int pin, output int cyc);
    @(negedge clk);
    if (is_rx) begin
      rx_req = 1'b1;
    end else begin
      tx_req = 1'b1;
    end
    @(negedge clk);
    cyc = 0;
    while (cyc < 40 && pins[pin] !== 1'b1) begin
      @(negedge clk);
      cyc++;
    end
    // Spacing wider than the longest delay
    repeat (6) @(negedge clk);
  endtask : fire

  // Drop the link, present a new skew, bring a fresh link up
  task link_up(input logic [4:0] sk);
    @(posedge clk);
    link <= 1'b0;
    @(posedge clk);
    skew <= sk;
    @(posedge clk);
    link <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : link_up

  task report_and_stop;
    $display("CHECKS %0d MISMATCHES %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Hang guard: counts as a mismatch
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    {wr, rd, tx_req, rx_req, tx_ev, rx_ev, link, gig, mst} = '0;
    {addr, wdata, skew} = '0;
    errors = 0;
    tests_run = 0;
    seed = 99;
    exp_cnt = 0;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    // Reset values, unmapped address last
    foreach (dut_addrs[i]) begin
      rd_reg(dut_addrs[i], d);
      `CHK(d, 16'h0000)
    end
    @(posedge clk);
    #1 `CHK(rdata, 16'h0000)
    $display("TEST reset done");
    // Read-write places keep random data; status and holes do not
    foreach (rw_addrs[i]) begin
      wdata_r = 16'($random(seed));
      wr_reg(rw_addrs[i], wdata_r);
      rd_reg(rw_addrs[i], d);
      `CHK(d, wdata_r)
    end
    wr_reg(sfdtp_pkg::ADDR_SKEW, 16'hffff);
    rd_reg(sfdtp_pkg::ADDR_SKEW, d);
    `CHK(d, 16'h0000)
    wr_reg(10'h3ff, 16'hffff);
    rd_reg(10'h3ff, d);
    `CHK(d, 16'h0000)
    $display("TEST registers done");
    // Restart bit gives exactly one pulse and reads back clear
    wr_reg(sfdtp_pkg::ADDR_CTRL, 16'h4000);
    n = 0;
    repeat (4) begin
      #1 n += int'(restart === 1'b1);
      @(posedge clk);
    end
    `CHK(n, 1)
    rd_reg(sfdtp_pkg::ADDR_CTRL, d);
    `CHK(d & 16'h4000, 16'h0000)
    $display("TEST restart done");
    // Enable clear: routed pins stay quiet
    wr_reg(sfdtp_pkg::ADDR_RCFG, 16'h0000);
    wr_reg(sfdtp_pkg::ADDR_MUX1, 16'h0021);
    wr_reg(sfdtp_pkg::ADDR_MUX2, 16'h0000);
    wr_reg(sfdtp_pkg::ADDR_PHASE, 16'h0000);
    fire(1'b0, 0, n);
    `CHK(n, 40)
    fire(1'b1, 1, n);
    `CHK(n, 40)
    $display("TEST enable done");
    // Every select code on pins 2 and 3; pin 0 transmit, pin 1 receive
    wr_reg(sfdtp_pkg::ADDR_RCFG, 16'h0080);
    for (int c = 0; c < 16; c++) begin
      wr_reg(sfdtp_pkg::ADDR_MUX2, 16'(c * 17));
      fire(1'b0, 0, n);
      `CHK(n, 2)
      fire(1'b1, 1, n);
      `CHK(n, 2)
      exp_cnt += 2 + 2 * (int'(c == 1) + int'(c == 2));
    end
    $display("TEST routing done");
    // Phase steps, full-scale corner first
    for (int i = 0; i < 6; i++) begin
      t = (i == 0) ? 4'hf : (i == 1) ? 4'h1 : 4'($random(seed));
      r = (i == 0) ? 4'hf : 4'($random(seed));
      wr_reg(sfdtp_pkg::ADDR_PHASE, {8'h00, r, t});
      fire(1'b0, 0, n);
      `CHK(n, lat(int'(t) * 8))
      fire(1'b1, 1, n);
      `CHK(n, lat(int'(r) * 8))
      exp_cnt += 2;
    end
    `CHK(int'(cap_cnt), exp_cnt)
    $display("TEST phase done");
    // Gigabit skew: zero, above the clamp, then random
    wr_reg(sfdtp_pkg::ADDR_PHASE, 16'h0030);
    wr_reg(sfdtp_pkg::ADDR_SYNC, sfdtp_pkg::SYNC_INIT_VAL);
    gig <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      s = (i == 0) ? 5'd0 : (i == 1) ? 5'd20 : 5'($random(seed));
      @(posedge clk) mst <= i[0];
      link_up(s);
      rd_reg(sfdtp_pkg::ADDR_SKEW, d);
      `CHK(d, exp_stat(s, i[0]))
      fire(1'b1, 1, n);
      `CHK(n, lat((3 + ((s > 5'd15) ? 15 : int'(s))) * 8))
      @(posedge clk) skew <= ~s;
      rd_reg(sfdtp_pkg::ADDR_SKEW, d);
      `CHK(d, exp_stat(s, i[0]))
    end
    // Status word clears two edges after the link drops
    @(posedge clk) link <= 1'b0;
    repeat (2) @(posedge clk);
    rd_reg(sfdtp_pkg::ADDR_SKEW, d);
    `CHK(d, 16'h0000)
    // Link formed without the init value gives no readout
    wr_reg(sfdtp_pkg::ADDR_SYNC, 16'h1234);
    link_up(5'd5);
    rd_reg(sfdtp_pkg::ADDR_SKEW, d);
    `CHK(d, 16'h0000)
    // 100Mb: no readout, no skew on the receive pulse
    wr_reg(sfdtp_pkg::ADDR_SYNC, sfdtp_pkg::SYNC_INIT_VAL);
    gig <= 1'b0;
    link_up(5'd5);
    rd_reg(sfdtp_pkg::ADDR_SKEW, d);
    `CHK(d, 16'h0000)
    fire(1'b1, 1, n);
    `CHK(n, lat(24))
    `CHK(wide, 1'b0)
    $display("TEST skew done");
    report_and_stop();
  end
endmodule : sfdtp_top_tb

`default_nettype wire
